// ==== hdl/piw_pkg.sv ====
package piw_pkg;

  // Printed offsets are byte offsets not all multiple of four: kept as indices
  localparam logic [7:0] IDX_BURST_SLICE_TIMER = 8'h1b;
  localparam logic [7:0] IDX_IO_WINDOW_LOWER = 8'h1c;
  localparam logic [7:0] IDX_IO_WINDOW_UPPER = 8'h1d;
  localparam logic [7:0] IDX_DOWNSTREAM_STATUS = 8'h1e;
  // Own registers for interrupt mask and link-side control bits
  localparam logic [7:0] IDX_IRQ_MASK = 8'h20;
  localparam logic [7:0] IDX_BRIDGE_CONTROL = 8'h21;

  localparam int ADDR_W = 12;
  localparam logic [7:0] BURST_SLICE_VALUE = 8'h00;
  localparam logic [3:0] WINDOW_RESET = 4'h0;
  localparam logic [3:0] IO_WIDTH_16BIT = 4'h0;
  localparam logic [11:0] LOWER_FILL = 12'h000;
  localparam logic [11:0] UPPER_FILL = 12'hfff;

  // Status bit positions
  localparam int POISON_BIT = 15;
  localparam int ERRMSG_BIT = 14;
  localparam int UNSUP_BIT = 13;
  localparam logic [2:0] STATUS_RESET = 3'h0;
  // Control bit positions
  localparam int PARITY_EN_BIT = 0;
  localparam int SYSERR_FWD_BIT = 1;

  // Events seen on the downstream link, one cycle pulses
  typedef struct packed {
    logic poisoned_tlp;
    logic error_message;
    logic unsupported_cpl;
  } piw_link_events_t;

  // I/O request to be decoded against the window
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
  } piw_io_req_t;

endpackage : piw_pkg

// ==== hdl/piw_bridge.sv ====
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - Burst slice timer register is read-only and always reads zero.
// - Forward I/O only when address bits 15:12 lie within window, inclusive.
// - Lower bound decodes with address bits 11:0 as zero.
// - Upper bound decodes with address bits 11:0 as all ones.
// - Lower register bits 7:4 writable, hold address 15:12, reset zero.
// - Lower register bits 3:0 read zero: 16-bit I/O only.
// - Upper register bits 7:4 read-write, reset zero, hold upper bound.
// - Upper register bits 3:0 read-only zero, 16-bit capability.
// - Status bit 15 set on poisoned packet, regardless of parity enable.
// - Status bit 14 set on received fatal or nonfatal error message.
// - Bit 14 recording ignores the system-error forwarding enable.
// - Status bit 13 set on completion with Unsupported Request status.
module piw_bridge (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [piw_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  input wire piw_pkg::piw_link_events_t LINK_EVENTS_I,
  input wire piw_pkg::piw_io_req_t IO_REQ_I,
  output logic IO_FORWARD_O,
  output logic IO_FORWARD_VALID_O,
  output logic PARITY_RESPONSE_EN_O,
  output logic SYSERR_FORWARD_EN_O,
  output logic IRQ_O
);
  import piw_pkg::*;

  logic [3:0] io_window_lower_r;
  logic [3:0] io_window_upper_r;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] irq_mask_r;
  logic [1:0] bridge_control_r;
  logic [2:0] event_vec;
  logic [2:0] clear_vec;
  logic [ADDR_W-3:0] word_idx;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [31:0] rd_mux;
  logic [15:0] lower_addr;
  logic [15:0] upper_addr;
  logic fwd_r;
  logic fwd_valid_r;
  logic [2:0] set_vec;

  // APB decode; zero wait states, so the access phase completes at once
  // Full word index kept, so high addresses cannot alias onto mapped words
  assign word_idx = PADDR_I[ADDR_W-1:2];
  assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
  assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;
  assign PREADY_O = 1'b1;

  // Address hits one of the mapped words
  always_comb
  begin
    case (word_idx)
      IDX_BURST_SLICE_TIMER,
      IDX_IO_WINDOW_LOWER,
      IDX_IO_WINDOW_UPPER,
      IDX_DOWNSTREAM_STATUS,
      IDX_IRQ_MASK,
      IDX_BRIDGE_CONTROL: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Unmapped access answers with an error in the access phase
  assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;

  // Window lower field, only the top nibble holds state
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      io_window_lower_r <= WINDOW_RESET;
    else if (wr_en && word_idx == IDX_IO_WINDOW_LOWER && PSTRB_I[0])
      io_window_lower_r <= PWDATA_I[7:4];
  end

  // Window upper field
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      io_window_upper_r <= WINDOW_RESET;
    else if (wr_en && word_idx == IDX_IO_WINDOW_UPPER && PSTRB_I[0])
      io_window_upper_r <= PWDATA_I[7:4];
  end

  // Mask register, same layout as status bits 15:13
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      irq_mask_r <= STATUS_RESET;
    else if (wr_en && word_idx == IDX_IRQ_MASK && PSTRB_I[1])
      irq_mask_r <= PWDATA_I[POISON_BIT:UNSUP_BIT];
  end

  // Bridge control bits; steer nothing in status recording
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      bridge_control_r <= 2'h0;
    else if (wr_en && word_idx == IDX_BRIDGE_CONTROL && PSTRB_I[0])
      bridge_control_r <= {PWDATA_I[SYSERR_FWD_BIT], PWDATA_I[PARITY_EN_BIT]};
  end

  assign PARITY_RESPONSE_EN_O = bridge_control_r[0];
  assign SYSERR_FORWARD_EN_O = bridge_control_r[1];

  // Raw link events; enables are deliberately not part of these terms
  assign event_vec[2] = LINK_EVENTS_I.poisoned_tlp;
  assign event_vec[1] = LINK_EVENTS_I.error_message;
  assign event_vec[0] = LINK_EVENTS_I.unsupported_cpl;

  // Write-one-to-clear on the upper byte of the status halfword
  assign clear_vec = (wr_en && word_idx == IDX_DOWNSTREAM_STATUS && PSTRB_I[1]) ?
                     PWDATA_I[POISON_BIT:UNSUP_BIT] : 3'h0;
  assign set_vec = event_vec;

  // Per-bit sticky update; a set in the clear cycle wins so no event is lost
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_status
      always_comb
      begin
        if (set_vec[g])
          status_nxt[g] = 1'b1;
        else if (clear_vec[g])
          status_nxt[g] = 1'b0;
        else
          status_nxt[g] = status_r[g];
      end
    end
  endgenerate

  // Status flops
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      status_r <= STATUS_RESET;
    else
      status_r <= status_nxt;
  end

  // Level interrupt while any unmasked status bit is set
  assign IRQ_O = |(status_r & irq_mask_r);

  // Window bounds widened to full 16-bit I/O addresses
  assign lower_addr = {io_window_lower_r, LOWER_FILL};
  assign upper_addr = {io_window_upper_r, UPPER_FILL};

  // Forward decision registered one cycle after the request
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      fwd_r <= 1'b0;
      fwd_valid_r <= 1'b0;
    end
    else
    begin
      fwd_valid_r <= IO_REQ_I.valid;
      // Inclusive compare on full addresses equals compare on bits 15:12
      fwd_r <= IO_REQ_I.valid && (IO_REQ_I.addr >= lower_addr) &&
               (IO_REQ_I.addr <= upper_addr);
    end
  end

  assign IO_FORWARD_O = fwd_r;
  assign IO_FORWARD_VALID_O = fwd_valid_r;

  // Read mux; status sits in bits 15:13, the rest reads zero
  always_comb
  begin
    rd_mux = 32'h0;
    case (word_idx)
      IDX_BURST_SLICE_TIMER: rd_mux = {24'h0, BURST_SLICE_VALUE};
      IDX_IO_WINDOW_LOWER: rd_mux = {24'h0, io_window_lower_r, IO_WIDTH_16BIT};
      IDX_IO_WINDOW_UPPER: rd_mux = {24'h0, io_window_upper_r, IO_WIDTH_16BIT};
      IDX_DOWNSTREAM_STATUS: rd_mux = {16'h0, status_r, 13'h0};
      IDX_IRQ_MASK: rd_mux = {16'h0, irq_mask_r, 13'h0};
      IDX_BRIDGE_CONTROL: rd_mux = {30'h0, bridge_control_r};
      default: rd_mux = 32'h0;
    endcase
  end

  // Read data held in a flop, loaded in the setup cycle
  always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      PRDATA_O <= 32'h0;
    else if (PSEL_I && !PENABLE_I && !PWRITE_I)
      PRDATA_O <= rd_mux;
  end

  // Keeps the read strobe meaningful for lint; no read side effects exist
  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : piw_bridge

// ==== test/piw_bridge_asserts.sv ====
`timescale 1ns/1ps
module piw_bridge_asserts (
  input wire logic SYS_CLK_I,
  input wire logic RSTN_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [piw_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [31:0] PRDATA_O,
  input wire logic PSLVERR_O,
  input wire piw_pkg::piw_link_events_t LINK_EVENTS_I,
  input wire piw_pkg::piw_io_req_t IO_REQ_I,
  input wire logic IO_FORWARD_O,
  input wire logic IO_FORWARD_VALID_O,
  input wire logic IRQ_O
);
  import piw_pkg::*;
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Access phase of a write, and of a read to one address
  sequence s_wr; PSEL_I && PENABLE_I && PWRITE_I; endsequence
  sequence s_rd(a); PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == a; endsequence
  property p_tmr; s_rd(12'h06c) |-> PRDATA_O == 32'h0 && !PSLVERR_O; endproperty
  a_tmr: assert property (p_tmr) else $error("timer read not zero");
  property p_low; s_rd(12'h070) |-> PRDATA_O[3:0] == 4'h0; endproperty
  a_low: assert property (p_low) else $error("lower width field not zero");
  property p_upp; s_rd(12'h074) |-> PRDATA_O[3:0] == 4'h0; endproperty
  a_upp: assert property (p_upp) else $error("upper width field not zero");
  property p_fvl; IO_REQ_I.valid |=> IO_FORWARD_VALID_O; endproperty
  a_fvl: assert property (p_fvl) else $error("decode result missing");
  property p_fwd; IO_FORWARD_O |-> IO_FORWARD_VALID_O; endproperty
  a_fwd: assert property (p_fwd) else $error("forward without request");
  property p_fwn; !IO_REQ_I.valid |=> !IO_FORWARD_O; endproperty
  a_fwn: assert property (p_fwn) else $error("forward with no request");
  // Interrupt only rises on a link event or a mask write
  property p_irq; $rose(IRQ_O) |-> $past(|LINK_EVENTS_I) || $past(PSEL_I && PWRITE_I);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt rose without cause");
  property p_clr; $fell(IRQ_O) |-> $past(PSEL_I && PENABLE_I && PWRITE_I); endproperty
  a_clr: assert property (p_clr) else $error("interrupt fell without write");
endmodule : piw_bridge_asserts

// ==== test/piw_link_dev.sv ====
`timescale 1ns/1ps
module piw_link_dev (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] fire_i,
  output piw_pkg::piw_link_events_t ev_o
);
  import piw_pkg::*;
  // Link events are single-cycle pulses, low between packets
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ev_o <= '0;
    else
      ev_o <= fire_i;
  end
endmodule : piw_link_dev

// ==== test/piw_bridge_tb_top.sv ====
`timescale 1ns/1ps
module piw_bridge_tb_top;
  import piw_pkg::*;
  logic clk, rstn, psel, pen, pwr, irq, fwd, perr, rdy, e;
  logic fv, pe, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [47:0] o;
  logic [2:0] fire;
  piw_link_events_t ev;
  piw_io_req_t req;
  int error_cnt = 0;
  int samples_checked = 0;
  // Op nibble: 0 read+compare, 1 write, 2 link event, 4 interrupt level
  localparam logic [47:0] OPS [32] = '{48'h006c00000000, 48'h007000000000,
    48'h007400000000, 48'h007800000000, 48'h106c000000ff, 48'h1070000000ff,
    48'h1074000000ff, 48'h006c00000000, 48'h0070000000f0, 48'h0074000000f0,
    48'h107000000030, 48'h107400000050, 48'h10800000e000, 48'h200000000004,
    48'h007800008000, 48'h400000000001, 48'h200000000002, 48'h00780000c000,
    48'h200000000001, 48'h00780000e000, 48'h107800000000, 48'h00780000e000,
    48'h107800008000, 48'h007800006000, 48'h107800006000, 48'h007800000000,
    48'h400000000000, 48'h108000000000, 48'h200000000004, 48'h400000000000,
    48'h10800000e000, 48'h400000000001};
  localparam logic [16:0] IOS [5] = '{17'h02fff, 17'h13000, 17'h15fff, 17'h06000, 17'h14abc};
  piw_link_dev link (.clk_i(clk), .rstn_i(rstn), .fire_i(fire), .ev_o(ev));
  piw_bridge dut (.SYS_CLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hf), .PRDATA_O(prdata),
    .PREADY_O(rdy), .PSLVERR_O(perr), .LINK_EVENTS_I(ev), .IO_REQ_I(req),
    .IO_FORWARD_O(fwd), .IO_FORWARD_VALID_O(fv), .PARITY_RESPONSE_EN_O(pe),
    .SYSERR_FORWARD_EN_O(se), .IRQ_O(irq));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Setup, access, then hold until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk);
    pen <= 1'h1;
    @(posedge clk);
    while (rdy !== 1'h1)
      @(posedge clk);
    r = prdata;
    e = perr;
    {psel, pen} <= 2'h0;
  endtask : apb
  task print_verdict;
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Generous bound: the whole sequence needs about 110 cycles
  initial
  begin
    #20000;
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    {rstn, psel, pen, pwr, paddr, pwdata, fire, req} = '0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    foreach (OPS[i])
    begin
      o = OPS[i];
      if (o[45])
      begin
        @(posedge clk);
        fire <= o[2:0];
        @(posedge clk);
        fire <= 3'h0;
      end
      else if (o[46])
        #1 chk({31'h0, irq}, o[31:0]);
      else
        apb(o[44], o[43:32], o[31:0]);
      if (o[47:44] == 4'h0)
        chk(r, o[31:0]);
    end
    // Window 3..5: probe both edges of each 4 KB bound
    foreach (IOS[i])
    begin
      @(posedge clk);
      req <= {1'h1, IOS[i][15:0]};
      @(posedge clk);
      req <= '0;
      #1 chk({31'h0, fwd}, {31'h0, IOS[i][16]});
      chk({31'h0, fv}, 32'h1);
    end
    // Both control enables on; error recording must not depend on them
    apb(1'h1, 12'h084, 32'h3);
    apb(1'h0, 12'h084, 32'h0);
    chk(r, 32'h3);
    chk({30'h0, se, pe}, 32'h3);
    @(posedge clk);
    fire <= 3'h2;
    @(posedge clk);
    fire <= 3'h0;
    apb(1'h0, 12'h078, 32'h0);
    chk(r, 32'hc000);
    apb(1'h0, 12'h0fc, 32'h0);
    chk({e, r[30:0]}, 32'h80000000);
    print_verdict();
  end
endmodule : piw_bridge_tb_top
bind piw_bridge piw_bridge_asserts u_chk (.SYS_CLK_I, .RSTN_I, .PSEL_I, .PENABLE_I,
  .PWRITE_I, .PADDR_I, .PRDATA_O, .PSLVERR_O, .LINK_EVENTS_I, .IO_REQ_I, .IO_FORWARD_O,
  .IO_FORWARD_VALID_O, .IRQ_O);
